// ---- hdl/fce_tx.sv ----
// Transmit encoder: parity, CRC, ordered sets, 8b/10b, raw bypass
//
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "fce_tx_regs.svh"
module fce_tx (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic serializer_byte_clock_in,
  input wire logic host_word_clock,
  input wire logic [31:0] host_tx_word,
  input wire logic [3:0] host_tx_parity,
  input wire logic host_ordered_set_flag,
  input wire logic host_crc_generate_select,
  input wire logic bypass_extra_bit_a,
  input wire logic bypass_extra_bit_b,
  input wire logic link_idle_request,
  output logic [9:0] encoded_byte_out,
  output logic encoded_byte_clock_out,
  output logic word_rate_reference,
  output logic tx_parity_fault,
  output logic tx_crc_fault
);

  fce_pkg::fce_state_t s;
  fce_pkg::fce_state_t n;

  // 5b/6b codes, abcdei, negative disparity column
  function automatic logic [5:0] tbl6(input logic [4:0] x);
    logic [5:0] t;
    case (x)
      5'h00: t = 6'b100111;
      5'h01: t = 6'b011101;
      5'h02: t = 6'b101101;
      5'h03: t = 6'b110001;
      5'h04: t = 6'b110101;
      5'h05: t = 6'b101001;
      5'h06: t = 6'b011001;
      5'h07: t = 6'b111000;
      5'h08: t = 6'b111001;
      5'h09: t = 6'b100101;
      5'h0a: t = 6'b010101;
      5'h0b: t = 6'b110100;
      5'h0c: t = 6'b001101;
      5'h0d: t = 6'b101100;
      5'h0e: t = 6'b011100;
      5'h0f: t = 6'b010111;
      5'h10: t = 6'b011011;
      5'h11: t = 6'b100011;
      5'h12: t = 6'b010011;
      5'h13: t = 6'b110010;
      5'h14: t = 6'b001011;
      5'h15: t = 6'b101010;
      5'h16: t = 6'b011010;
      5'h17: t = 6'b111010;
      5'h18: t = 6'b110011;
      5'h19: t = 6'b100110;
      5'h1a: t = 6'b010110;
      5'h1b: t = 6'b110110;
      5'h1c: t = 6'b001110;
      5'h1d: t = 6'b101110;
      5'h1e: t = 6'b011110;
      default: t = 6'b101011;
    endcase
    return t;
  endfunction

  // 3b/4b codes, fghj, negative disparity column
  function automatic logic [3:0] tbl4(input logic [2:0] y);
    logic [3:0] t;
    case (y)
      3'h0: t = 4'b1011;
      3'h1: t = 4'b1001;
      3'h2: t = 4'b0101;
      3'h3: t = 4'b1100;
      3'h4: t = 4'b1101;
      3'h5: t = 4'b1010;
      3'h6: t = 4'b0110;
      default: t = 4'b1110;
    endcase
    return t;
  endfunction

  // One character; rd high means positive disparity; K covers K28.5 only
  function automatic logic [10:0] enc_char(input logic [7:0] b, input logic k,
                                           input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic rdm;
    logic [4:0] x;
    x = b[4:0];
    s6 = k ? 6'b001111 : tbl6(x);
    if (rd && (($countones(s6) != 3) || (!k && x == 5'h07)))
      s6 = ~s6;
    rdm = ($countones(s6) != 3) ? ~rd : rd;
    if (k)
      s4 = rdm ? 4'b1010 : 4'b0101;
    else
    begin
      s4 = tbl4(b[7:5]);
      // Alternate x.7 avoids a run of five equal bits
      if (b[7:5] == 3'h7 && ((!rdm && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
          (rdm && (x == 5'h0b || x == 5'h0d || x == 5'h0e))))
        s4 = 4'b0111;
      if (rdm && (($countones(s4) != 2) || b[7:5] == 3'h3))
        s4 = ~s4;
    end
    return {(($countones(s4) != 2) ? ~rdm : rdm), s6, s4};
  endfunction

  // Four characters, top byte first; returns final disparity and 40 bits
  function automatic logic [40:0] enc_word(input logic [31:0] w, input logic k3,
                                           input logic rd);
    logic [39:0] o;
    logic [10:0] t;
    logic r;
    r = rd;
    o = 40'h0;
    for (int i = 3; i >= 0; i--)
    begin
      t = enc_char(w[i*8 +: 8], k3 && (i == 3), r);
      o[i*10 +: 10] = t[9:0];
      r = t[10];
    end
    return {r, o};
  endfunction

  // Reflected CRC over one byte
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h0, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ `FCE_CRC_POLY) : (r >> 1);
    return r;
  endfunction

  // CRC over a word in line order
  function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] w);
    logic [31:0] r;
    r = c;
    for (int i = 3; i >= 0; i--)
      r = crc_byte(r, w[i*8 +: 8]);
    return r;
  endfunction

  function automatic logic is_eof(input logic [7:0] c);
    return c == `FCE_OS_EOFN || c == `FCE_OS_EOFT || c == `FCE_OS_ABORT_FRAME_END ||
           c == `FCE_OS_INVALID_FRAME_END;
  endfunction

  // Odd parity of a byte: high when ones even
  function automatic logic odd_par(input logic [7:0] b);
    return ~^b;
  endfunction

  // Bypass pin order puts the first raw bit on output bit 0
  function automatic logic [9:0] rev10(input logic [9:0] x);
    logic [9:0] r;
    for (int i = 0; i < 10; i++)
      r[i] = x[9 - i];
    return r;
  endfunction

  // Ordered set from a code; unknown codes pass the low three bytes
  function automatic logic [40:0] enc_os(input logic [7:0] code, input logic [23:0] low,
                                         input logic rd);
    logic [23:0] tail;
    logic r;
    r = rd;
    case (code)
      `FCE_OS_IDLE:
      begin
        tail = {`FCE_D214, `FCE_D215, `FCE_D215};
        r = 1'b0;
      end
      `FCE_OS_RRDY:
      begin
        tail = {`FCE_D214, `FCE_D102, `FCE_D102};
        r = 1'b0;
      end
      `FCE_OS_EOFN: tail = {rd ? `FCE_D215 : `FCE_D214, `FCE_D216, `FCE_D216};
      `FCE_OS_EOFT: tail = {rd ? `FCE_D215 : `FCE_D214, `FCE_D213, `FCE_D213};
      `FCE_OS_ABORT_FRAME_END: tail = {rd ? `FCE_D215 : `FCE_D214, `FCE_D217, `FCE_D217};
      `FCE_OS_INVALID_FRAME_END: tail = {rd ? `FCE_D105 : `FCE_D104, `FCE_D216, `FCE_D216};
      default: tail = low;
    endcase
    return enc_word({`FCE_K285, tail}, 1'b1, r);
  endfunction

  // Normal and terminate ends become invalid in a damaged frame
  function automatic logic [7:0] end_code(input logic [7:0] c, input logic bad);
    if (bad && (c == `FCE_OS_EOFN || c == `FCE_OS_EOFT))
      return `FCE_OS_INVALID_FRAME_END;
    return c;
  endfunction

  // Next state of the whole block
  always_comb
  begin
    fce_pkg::fce_host_t hin;
    logic [7:0] top;
    logic flag;
    logic pe;
    logic perr_now;
    logic cbad;
    logic [31:0] fcs;
    logic [39:0] raw;
    hin = s.in_s2;
    top = 8'h0;
    flag = 1'b0;
    pe = 1'b0;
    perr_now = 1'b0;
    cbad = 1'b0;
    fcs = 32'h0;
    raw = 40'h0;
    n = s;

    // Two-stage synchronisers for every pin from outside hclk
    n.bclk_s1 = serializer_byte_clock_in;
    n.bclk_s2 = s.bclk_s1;
    n.bclk_d = s.bclk_s2;
    n.wclk_s1 = host_word_clock;
    n.wclk_s2 = s.wclk_s1;
    n.wclk_d = s.wclk_s2;
    n.in_s1.word = host_tx_word;
    n.in_s1.par = host_tx_parity;
    n.in_s1.flag = host_ordered_set_flag;
    n.in_s1.crcsel = host_crc_generate_select;
    n.in_s1.rawa = bypass_extra_bit_a;
    n.in_s1.rawb = bypass_extra_bit_b;
    n.in_s1.idle = link_idle_request;
    n.in_s2 = s.in_s1;

    // Bus slave: zero wait states, always OKAY
    n.hready = 1'b1;
    n.hresp = 1'b0;
    if (s.ap.sel && s.ap.wr && s.ap.addr == `FCE_CTRL_OFF)
    begin
      n.ctrl.pdis = hwdata[`FCE_CTRL_PDIS];
      n.ctrl.pmode = hwdata[`FCE_CTRL_PMODE];
      n.ctrl.byp = hwdata[`FCE_CTRL_BYP];
    end
    n.ap.sel = hsel && htrans[1] && hready && (hsize == `FCE_HSIZE_WORD);
    n.ap.wr = hwrite;
    n.ap.addr = haddr[7:0];
    // Read data is fetched in the address phase; control reads see a write just ahead
    n.hrdata = 32'h0;
    if (hsel && htrans[1] && hready && !hwrite)
    begin
      if (haddr[7:0] == `FCE_CTRL_OFF)
      begin
        n.hrdata[`FCE_CTRL_PDIS] = n.ctrl.pdis;
        n.hrdata[`FCE_CTRL_PMODE] = n.ctrl.pmode;
        n.hrdata[`FCE_CTRL_BYP] = n.ctrl.byp;
      end
      else if (haddr[7:0] == `FCE_STAT_OFF)
      begin
        n.hrdata[`FCE_STAT_PERR] = s.perr;
        n.hrdata[`FCE_STAT_CERR] = s.cerr;
        n.hrdata[`FCE_STAT_RD] = s.rd;
        n.hrdata[`FCE_STAT_FRAME] = s.in_frame;
        n.hrdata[`FCE_STAT_PEND] = s.eof_pend;
      end
    end

    // Byte slots follow rising edges of the serializer clock
    n.bclk_out = ~s.bclk_s2;
    if (s.bclk_s2 && !s.bclk_d)
    begin
      n.cnt = s.cnt + 2'h1;
      if (s.cnt == 2'h3)
      begin
        n.byte_out = s.line[39:30];
        n.cur = {s.line[29:0], 10'h0};
      end
      else
      begin
        n.byte_out = s.cur[39:30];
        n.cur = {s.cur[29:0], 10'h0};
      end
      // Word reference is high over the first two bytes of each word
      n.wref = (s.cnt == 2'h3) || (s.cnt == 2'h0);
    end

    // Host word taken mid-cycle, on the falling host clock, clear of its changes
    if (!s.wclk_s2 && s.wclk_d)
    begin
      flag = hin.flag;
      top = hin.word[31:24];
      if (hin.idle)
      begin
        flag = 1'b1;
        top = s.idle_prev ? `FCE_OS_IDLE : `FCE_OS_ABORT_FRAME_END;
      end
      n.idle_prev = hin.idle;
      pe = (hin.par[0] != odd_par(hin.word[7:0])) ||
           (hin.par[1] != odd_par(hin.word[15:8])) ||
           (hin.par[2] != odd_par(hin.word[23:16])) ||
           (hin.par[3] != (odd_par(hin.word[31:24]) ^ (s.ctrl.pmode & hin.flag)));
      perr_now = !s.ctrl.pdis && !hin.idle && pe;
      n.perr = perr_now;
      n.cerr = 1'b0;
      if (s.ctrl.byp)
      begin
        // Raw word skips checks and coding; link restarts from negative disparity
        raw = {hin.flag, hin.par[3], hin.word[31:24], hin.crcsel, hin.par[2],
               hin.word[23:16], hin.rawa, hin.par[1], hin.word[15:8], hin.rawb,
               hin.par[0], hin.word[7:0]};
        n.line = {rev10(raw[39:30]), rev10(raw[29:20]), rev10(raw[19:10]),
                  rev10(raw[9:0])};
        n.rd = 1'b0;
        n.perr = 1'b0;
        n.in_frame = 1'b0;
        n.eof_pend = 1'b0;
        n.frame_bad = 1'b0;
        n.crc = `FCE_CRC_INIT;
      end
      else if (s.eof_pend)
      begin
        // Latched end set goes out now; the host word is dropped
        {n.rd, n.line} = enc_os(s.eof_code, 24'h0, s.rd);
        n.perr = 1'b0;
        n.eof_pend = 1'b0;
        n.in_frame = 1'b0;
        n.frame_bad = 1'b0;
        n.crc = `FCE_CRC_INIT;
      end
      else if (flag && is_eof(top) && hin.crcsel && s.in_frame)
      begin
        // Generated CRC word goes first, low byte leading
        fcs = ~s.crc;
        {n.rd, n.line} = enc_word({fcs[7:0], fcs[15:8], fcs[23:16], fcs[31:24]},
                                  1'b0, s.rd);
        n.eof_pend = 1'b1;
        n.eof_code = end_code(top, s.frame_bad || perr_now);
      end
      else if (flag)
      begin
        // Check mode compares the residue left by the frame's own CRC
        cbad = !hin.crcsel && s.in_frame && is_eof(top) &&
               (s.crc != `FCE_CRC_RESID);
        {n.rd, n.line} = enc_os(end_code(top, s.frame_bad || perr_now || cbad),
                                hin.word[23:0], s.rd);
        n.cerr = cbad;
        n.in_frame = !is_eof(top);
        n.frame_bad = 1'b0;
        n.crc = `FCE_CRC_INIT;
      end
      else
      begin
        // Data word: coded and folded into the running CRC
        {n.rd, n.line} = enc_word(hin.word, 1'b0, s.rd);
        n.crc = crc_word(s.crc, hin.word);
        n.frame_bad = s.frame_bad || perr_now;
      end
    end
  end

  // State register; line starts as zeros until the first host word
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.hready <= 1'b1;
      s.crc <= `FCE_CRC_INIT;
      s.cnt <= 2'h3; // First slot opens a whole word, so no short reference pulse
    end
    else
    begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign hrdata = s.hrdata;
  assign hreadyout = s.hready;
  assign hresp = s.hresp;
  assign encoded_byte_out = s.byte_out;
  assign encoded_byte_clock_out = s.bclk_out;
  assign word_rate_reference = s.wref;
  assign tx_parity_fault = s.perr;
  assign tx_crc_fault = s.cerr;

endmodule // fce_tx

// ---- hdl/fce_tx_regs.svh ----
// Constants of the transmit encoder: offsets, fields, codes, CRC
`ifndef FCE_TX_REGS_SVH
`define FCE_TX_REGS_SVH
`define FCE_CTRL_OFF 8'h00
`define FCE_STAT_OFF 8'h04
`define FCE_CTRL_PDIS 0
`define FCE_CTRL_PMODE 1
`define FCE_CTRL_BYP 2
`define FCE_STAT_PERR 0
`define FCE_STAT_CERR 1
`define FCE_STAT_RD 2
`define FCE_STAT_FRAME 3
`define FCE_STAT_PEND 4
`define FCE_HSIZE_WORD 3'h2
`define FCE_OS_IDLE 8'h01
`define FCE_OS_RRDY 8'h02
`define FCE_OS_EOFN 8'h11
`define FCE_OS_EOFT 8'h12
`define FCE_OS_ABORT_FRAME_END 8'h13
`define FCE_OS_INVALID_FRAME_END 8'h14
`define FCE_K285 8'hbc
`define FCE_D102 8'h4a
`define FCE_D104 8'h8a
`define FCE_D105 8'haa
`define FCE_D213 8'h75
`define FCE_D214 8'h95
`define FCE_D215 8'hb5
`define FCE_D216 8'hd5
`define FCE_D217 8'hf5
`define FCE_CRC_POLY 32'hedb88320
`define FCE_CRC_INIT 32'hffffffff
`define FCE_CRC_RESID 32'hdebb20e3
`endif

// ---- hdl/fce_pkg.sv ----
// Types shared by the transmit encoder
package fce_pkg;
  // One host word as it arrives on the pins
  typedef struct packed {
    logic [31:0] word;
    logic [3:0] par;
    logic flag;
    logic crcsel;
    logic rawa;
    logic rawb;
    logic idle;
  } fce_host_t;
  // Software control bits
  typedef struct packed {
    logic byp;
    logic pmode;
    logic pdis;
  } fce_ctrl_t;
  // Captured bus address phase
  typedef struct packed {
    logic sel;
    logic wr;
    logic [7:0] addr;
  } fce_ahb_ap_t;
  // Whole state of the encoder
  typedef struct packed {
    logic bclk_s1;
    logic bclk_s2;
    logic bclk_d;
    logic wclk_s1;
    logic wclk_s2;
    logic wclk_d;
    fce_host_t in_s1;
    fce_host_t in_s2;
    fce_ctrl_t ctrl;
    fce_ahb_ap_t ap;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic idle_prev;
    logic rd;
    logic in_frame;
    logic frame_bad;
    logic eof_pend;
    logic [7:0] eof_code;
    logic [31:0] crc;
    logic [39:0] line;
    logic [39:0] cur;
    logic [1:0] cnt;
    logic [9:0] byte_out;
    logic bclk_out;
    logic wref;
    logic perr;
    logic cerr;
  } fce_state_t;
endpackage

// ---- dv/fce_tx_checker.sv ----
// Port assertions for the transmit encoder
`timescale 1ns/1ps
module fce_tx_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic host_word_clock,
  input wire logic host_crc_generate_select,
  input wire logic link_idle_request,
  input wire logic encoded_byte_clock_out,
  input wire logic word_rate_reference,
  input wire logic tx_parity_fault,
  input wire logic tx_crc_fault
);
  logic [7:0] idle_cnt;
  logic [7:0] gen_cnt;
  logic [7:0] cerr_cnt;
  logic bclk_armed;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Run lengths; long runs let a fault word from before the run drain first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      idle_cnt <= 8'h00;
      gen_cnt <= 8'h00;
      cerr_cnt <= 8'h00;
      bclk_armed <= 1'b0;
    end
    else
    begin
      idle_cnt <= link_idle_request ? idle_cnt + {7'h0, ~&idle_cnt} : 8'h00;
      gen_cnt <= host_crc_generate_select ? gen_cnt + {7'h0, ~&gen_cnt} : 8'h00;
      cerr_cnt <= tx_crc_fault ? cerr_cnt + 8'h01 : 8'h00;
      // First byte clock high after reset is the inverted reset level, not a slot
      bclk_armed <= bclk_armed | encoded_byte_clock_out;
    end
  end
  // Two bytes of reference high, eight cycles each
  sequence wref_hi16;
    word_rate_reference [*8] ##1 word_rate_reference [*8];
  endsequence
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not OKAY");
  rdata_idle_a: assert property (!$past(hsel && htrans[1] && !hwrite && hready) |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  perr_idle_a: assert property (idle_cnt >= 8'h48 |-> !tx_parity_fault)
    else $error("parity fault while idle");
  cerr_gen_a: assert property (gen_cnt >= 8'h48 |-> !tx_crc_fault)
    else $error("crc fault in generate mode");
  cerr_width_a: assert property (tx_crc_fault |-> cerr_cnt <= 8'h22)
    else $error("crc fault too long");
  cerr_min_a: assert property ($fell(tx_crc_fault) |-> cerr_cnt >= 8'h1e)
    else $error("crc fault too short");
  wref_shape_a: assert property ($rose(word_rate_reference) |-> wref_hi16 ##1 !word_rate_reference)
    else $error("word reference shape wrong");
  bclk_period_a: assert property ((bclk_armed && $rose(encoded_byte_clock_out)) |->
    ##8 $rose(encoded_byte_clock_out))
    else $error("byte clock period wrong");
  perr_time_a: assert property ($changed(tx_parity_fault) |-> !$past(host_word_clock, 2))
    else $error("parity fault off the word edge");
  crc_seen_c: cover property ($rose(tx_crc_fault));
endmodule // fce_tx_checker

// ---- dv/fce_link_model.sv ----
// Far side: serializer byte clock and host word register
`timescale 1ns/1ps
module fce_link_model (
  input wire fce_pkg::fce_host_t nxt,
  output logic byte_clk,
  output logic word_clk,
  output fce_pkg::fce_host_t pins
);
  logic [1:0] div = 2'h0;
  // Free-running byte clock of 64 ns, offset so edges miss the system clock
  initial
  begin
    byte_clk = 1'b0;
    #3.3;
    forever #32 byte_clk = ~byte_clk;
  end
  // Host word clock at a quarter of the byte rate, as the reference asks
  always @(posedge byte_clk) div <= div + 2'h1;
  assign word_clk = div[1];
  // Host changes its word just after its clock rises, holds it a period
  initial pins = '0;
  always @(posedge word_clk) pins <= nxt;
endmodule // fce_link_model

// ---- dv/fce_encoder_transmit_path_tb_top.sv ----
// Self-checking bench of the transmit encoder
`timescale 1ns/1ps
`include "fce_tx_regs.svh"
module fce_encoder_transmit_path_tb_top;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic bclk;
  logic wclk;
  logic [9:0] eb;
  logic ebclk;
  logic wref;
  logic perr;
  logic cerr;
  fce_pkg::fce_host_t nxt;
  fce_pkg::fce_host_t pins;
  logic [31:0] r;
  logic [39:0] cap = '0;
  logic [39:0] line_w = '0;
  logic wref_l = 1'b0;
  logic pm = 1'b0;
  int bi = 0;
  int n_fail = 0;
  int n_tests = 0;
  event got;
  logic [31:0] dat [3] = '{32'h12345678, 32'h9abcdef0, 32'h0f1e2d3c};
  fce_tx i_fce_tx (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .serializer_byte_clock_in(bclk),
    .host_word_clock(wclk), .host_tx_word(pins.word), .host_tx_parity(pins.par),
    .host_ordered_set_flag(pins.flag), .host_crc_generate_select(pins.crcsel),
    .bypass_extra_bit_a(pins.rawa), .bypass_extra_bit_b(pins.rawb),
    .link_idle_request(pins.idle), .encoded_byte_out(eb), .encoded_byte_clock_out(ebclk),
    .word_rate_reference(wref), .tx_parity_fault(perr), .tx_crc_fault(cerr));
  fce_link_model i_fce_link_model (.nxt(nxt), .byte_clk(bclk), .word_clk(wclk), .pins(pins));
  // Gather four bytes a word; the reference marks the top byte
  always @(posedge ebclk)
  begin
    cap = {cap[29:0], eb};
    bi = (wref && !wref_l) ? 0 : bi + 1;
    wref_l = wref;
    if (bi == 3)
    begin
      line_w = cap;
      ->got;
    end
  end
  task automatic chk(input logic [39:0] got_v, input logic [39:0] exp_v);
    n_tests++;
    if (got_v !== exp_v)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask
  task automatic stop_test;
    if (n_fail == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Single AHB transfer: address phase held until ready, then data phase
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
    input logic [2:0] sz);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // Host word with odd parity, top bit optionally covering the flag
  function automatic fce_pkg::fce_host_t mk(input logic [31:0] w, input logic f, input logic s);
    fce_pkg::fce_host_t h;
    h = '0;
    h.word = w;
    h.flag = f;
    h.crcsel = s;
    for (int i = 0; i < 4; i++) h.par[i] = ~^w[8*i+:8];
    if (pm) h.par[3] = ~^{w[31:24], f};
    return h;
  endfunction
  function automatic logic [31:0] crcb(input logic [31:0] c, input logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ `FCE_CRC_POLY : c >> 1;
    return c;
  endfunction
  // Raw line as the byte pins show it: lowest pin carries the top raw bit
  function automatic logic [39:0] rv(input logic [39:0] l);
    for (int i = 0; i < 40; i++) rv[i] = l[(i / 10) * 10 + 9 - i % 10];
  endfunction
  // One host word per word clock; faults settle a few cycles after the fall
  task automatic put(input fce_pkg::fce_host_t h);
    nxt = h;
    @(posedge wclk);
    @(negedge wclk);
    repeat (6) @(posedge hclk);
  endtask
  task automatic t_regs;
    ahb(1'b0, `FCE_CTRL_OFF, 32'h0, `FCE_HSIZE_WORD);
    chk(r, 32'h0);
    ahb(1'b1, `FCE_CTRL_OFF, 32'hffffffff, `FCE_HSIZE_WORD);
    ahb(1'b0, `FCE_CTRL_OFF, 32'h0, `FCE_HSIZE_WORD);
    chk(r, 32'h7);
    ahb(1'b1, `FCE_CTRL_OFF, 32'h0, 3'h0);
    ahb(1'b0, `FCE_CTRL_OFF, 32'h0, `FCE_HSIZE_WORD);
    chk(r, 32'h7);
    ahb(1'b0, 32'h08, 32'h0, `FCE_HSIZE_WORD);
    chk(r, 32'h0);
    ahb(1'b1, `FCE_CTRL_OFF, 32'h0, `FCE_HSIZE_WORD);
  endtask
  task automatic t_par;
    fce_pkg::fce_host_t h;
    h = mk(32'h3c5a0f81, 1'b0, 1'b0);
    put(h);
    chk(perr, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      h.par[i] = ~h.par[i];
      put(h);
      chk(perr, 1'b1);
      h.par[i] = ~h.par[i];
    end
    ahb(1'b1, `FCE_CTRL_OFF, 32'h1, `FCE_HSIZE_WORD);
    h.par = ~h.par;
    put(h);
    chk(perr, 1'b0);
    pm = 1'b1;
    ahb(1'b1, `FCE_CTRL_OFF, 32'h2, `FCE_HSIZE_WORD);
    h = mk(32'h2e000000, 1'b1, 1'b0);
    put(h);
    chk(perr, 1'b0);
    h.par[3] = ~^8'h2e;
    put(h);
    chk(perr, 1'b1);
    ahb(1'b0, `FCE_STAT_OFF, 32'h0, `FCE_HSIZE_WORD);
    chk(r[`FCE_STAT_PERR], 1'b1);
    chk(r[`FCE_STAT_FRAME], 1'b1);
    pm = 1'b0;
    ahb(1'b1, `FCE_CTRL_OFF, 32'h0, `FCE_HSIZE_WORD);
  endtask
  task automatic t_raw;
    fce_pkg::fce_host_t h;
    logic [39:0] e;
    ahb(1'b1, `FCE_CTRL_OFF, 32'h4, `FCE_HSIZE_WORD);
    for (int k = 0; k < 2; k++)
    begin
      h = mk(k ? 32'h40a5f13e : 32'h9be124c7, 1'b1, k[0]);
      h.par = 4'h5;
      h.rawa = k[0];
      h.rawb = !k[0];
      e = rv({h.flag, h.par[3], h.word[31:24], h.crcsel, h.par[2], h.word[23:16],
        h.rawa, h.par[1], h.word[15:8], h.rawb, h.par[0], h.word[7:0]});
      put(h);
      chk(perr, 1'b0);
      chk(cerr, 1'b0);
      for (int n = 0; n < 10 && line_w !== e; n++) @got;
      chk(line_w, e);
    end
    // Leave a plain data word on the pins, so no flagged raw word is coded later
    put(mk(32'h0, 1'b0, 1'b0));
    ahb(1'b1, `FCE_CTRL_OFF, 32'h0, `FCE_HSIZE_WORD);
  endtask
  task automatic t_os;
    put(mk(32'h0, 1'b0, 1'b0));
    put(mk(32'h8500ff00, 1'b1, 1'b0));
    for (int n = 0; n < 10 && line_w[39:30] !== 10'h0fa && line_w[39:30] !== 10'h305; n++) @got;
    chk(line_w[39:20] === 20'h3e98b || line_w[39:20] === 20'hc1674, 1'b1);
  endtask
  // Start set, three data words, sum word (check mode only), normal end
  task automatic frame(input logic bad, input logic s);
    logic [31:0] c;
    c = `FCE_CRC_INIT;
    put(mk(32'h2e001122, 1'b1, s));
    for (int i = 0; i < 3; i++)
    begin
      put(mk(dat[i], 1'b0, s));
      for (int b = 3; b >= 0; b--) c = crcb(c, dat[i][8*b+:8]);
    end
    c = ~c ^ {31'h0, bad};
    if (!s) put(mk({c[7:0], c[15:8], c[23:16], c[31:24]}, 1'b0, s));
    put(mk({`FCE_OS_EOFN, 24'h0}, 1'b1, s));
    chk(cerr, bad && !s);
    put(mk(32'h01000000, 1'b1, s));
    chk(cerr, 1'b0);
  endtask
  task automatic t_idle;
    fce_pkg::fce_host_t h;
    h = mk(32'h55aa00ff, 1'b0, 1'b1);
    put(h);
    h.par = ~h.par;
    h.idle = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      put(h);
      chk(perr, 1'b0);
    end
    chk(line_w[39:30], 10'h0fa);
    put(mk(32'h55aa00ff, 1'b0, 1'b0));
    chk(perr, 1'b0);
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // Hang guard, well beyond the expected run length
  initial
  begin
    #200000;
    n_fail++;
    stop_test();
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `FCE_HSIZE_WORD;
    hwdata = 32'h0;
    nxt = mk(32'h0, 1'b0, 1'b0);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_par();
    t_raw();
    t_os();
    frame(1'b0, 1'b0);
    frame(1'b1, 1'b0);
    frame(1'b0, 1'b0);
    frame(1'b1, 1'b1);
    t_idle();
    stop_test();
  end
endmodule // fce_encoder_transmit_path_tb_top
bind fce_tx fce_tx_checker i_fce_tx_checker (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hrdata, .hresp, .host_word_clock, .host_crc_generate_select, .link_idle_request,
  .encoded_byte_clock_out, .word_rate_reference, .tx_parity_fault, .tx_crc_fault);
